//--- cspc_defines.vh
// Behaviour
// R1: Power enable off halts and resets internals.
// R2: Transmit disabled holds serial output low.
// R3: Receive disabled: no interrupt, no update.
// R4: Mode bits change only while powered off.
// R5: Abort by power off; clock output stops.
// R6: Bit order 0 MSB first, 1 LSB first.
// R7: Single mode never raises transmit interrupt.
// R8: Single mode: transmit write while busy dropped.
// R9: Single receive-only: read while busy ignored.
// R10: Continuous mode chains transfers on new data.
// R11: Continuous receive-only restarts after each word.
// R12: Late receive read sets overrun flag.
// R13: Start trigger enable gates the trigger.
// R14: Transmit modes ignore start trigger enable.
// R15: Single receive: each read starts reception.
// R16: Continuous receive: trigger off stops chaining.
// R17: Slave operation keeps trigger enable set.
// R18: Busy must read 0 before receive off.
// R19: Bits 3 and 2 written as zero.
// R20: Clock register rewritten only while powered off.
// R21: Clock select: dividers, baud input, slave.
// R22: Busy set at trigger, cleared last edge.
// R23: Start by transmit write or receive read.
// R24: Master drives clock only while transferring.
`ifndef CSPC_DEFINES_VH
`define CSPC_DEFINES_VH

// Register word indices; the byte address is four times the index.
`define CSPC_IDX_CTL_MAIN    32'h0FFF_FD00
`define CSPC_IDX_CTL_CLOCK   32'h0FFF_FD01
`define CSPC_IDX_STATUS      32'h0FFF_FD03
`define CSPC_IDX_TX_DATA     32'h0FFF_FD08
`define CSPC_IDX_RX_DATA     32'h0FFF_FD09
`define CSPC_ADDR_CTL_MAIN   (`CSPC_IDX_CTL_MAIN << 2)
`define CSPC_ADDR_CTL_CLOCK  (`CSPC_IDX_CTL_CLOCK << 2)
`define CSPC_ADDR_STATUS     (`CSPC_IDX_STATUS << 2)
`define CSPC_ADDR_TX_DATA    (`CSPC_IDX_TX_DATA << 2)
`define CSPC_ADDR_RX_DATA    (`CSPC_IDX_RX_DATA << 2)

// Reset values.
`define CSPC_RST_CTL_MAIN    8'h01
`define CSPC_RST_CTL_CLOCK   3'h0
`define CSPC_RST_DATA        8'h00

// Main control field positions.
`define CSPC_BIT_PWR         7
`define CSPC_BIT_TXE         6
`define CSPC_BIT_RXE         5
`define CSPC_BIT_DIR         4
`define CSPC_BIT_TMS         1
`define CSPC_BIT_SCE         0

// Status field positions.
`define CSPC_BIT_BUSY        7
`define CSPC_BIT_OVE         0

// Clock select codes.
`define CSPC_CKS_BRG         3'h6
`define CSPC_CKS_SLAVE       3'h7

// Data width of one transfer.
`define CSPC_DATA_W          8

`endif

//--- cspc_clock.v
`timescale 1ns/1ps
`include "cspc_defines.vh"

// Serial clock generation and edge detection for master and slave.
module cspc_clock (
   // Clock and reset.
   input  wire       pclk,
   input  wire       presetn,
   // Control.
   input  wire       run,
   input  wire [2:0] cks,
   input  wire       brg_tick,
   // External clock in slave mode.
   input  wire       sck_in,
   // Clock out and edge events.
   output reg        sck_out_ff,
   output reg        sck_oe_n_ff,
   output wire       rise,
   output wire       fall
);

   reg  [5:0] div_ff;
   reg        ext_prev_ff;
   wire       master;
   wire [5:0] mask;
   wire       half;

   // Below the baud code, half period is two to the power of the code, in peripheral clocks.
   assign master = (cks != `CSPC_CKS_SLAVE);                           // [R21]
   assign mask   = (6'h01 << cks) - 6'h01;
   assign half   = (cks == `CSPC_CKS_BRG) ? brg_tick : ((div_ff & mask) == mask);

   // Edge events, only while a transfer runs.
   assign rise = run & (master ? (half & ~sck_out_ff) : (sck_in & ~ext_prev_ff));
   assign fall = run & (master ? (half & sck_out_ff) : (~sck_in & ext_prev_ff));

   // Divider restarts whenever the clock stops, so a started transfer's first half period is full.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff      <= 6'h00;
         sck_out_ff  <= 1'b1;
         sck_oe_n_ff <= 1'b1;
         ext_prev_ff <= 1'b1;
      end else begin
         div_ff      <= run ? div_ff + 6'h01 : 6'h00;
         ext_prev_ff <= sck_in;
         sck_oe_n_ff <= ~master;
         if (!run || !master) begin
            sck_out_ff <= 1'b1;                                        // [R24] [R5]
         end else if (half) begin
            sck_out_ff <= ~sck_out_ff;
         end
      end
   end

endmodule // cspc_clock

//--- cspc_shifter.v
`timescale 1ns/1ps
`include "cspc_defines.vh"

// Shift register: output changes on falling edges, input taken on rising edges.
module cspc_shifter #(
   parameter W  = `CSPC_DATA_W,
   parameter CW = 4
) (
   // Clock and reset.
   input  wire         pclk,
   input  wire         presetn,
   // Control.
   input  wire         clr,
   input  wire         load,
   input  wire [W-1:0] ld_data,
   input  wire         lsb_first,
   input  wire         out_en,
   // Serial edges and data.
   input  wire         rise,
   input  wire         fall,
   input  wire         sdi,
   output reg          sdo_ff,
   // Result.
   output wire         done,
   output wire [W-1:0] rx_word
);

   reg  [W-1:0]  sreg_ff;
   reg  [CW-1:0] cnt_ff;

   // Bit that leaves the register next.
   function first_bit;
      input [W-1:0] d;
      input         lsb;
      begin
         first_bit = lsb ? d[0] : d[W-1];                              // [R6]
      end
   endfunction

   // Received bits enter at the end opposite to the outgoing bit.
   assign rx_word = lsb_first ? {sdi, sreg_ff[W-1:1]} : {sreg_ff[W-2:0], sdi}; // [R6]
   assign done    = rise & (cnt_ff == W - 1);

   // Shifting and bit counting.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sreg_ff <= {W{1'b0}};
         cnt_ff  <= {CW{1'b0}};
         sdo_ff  <= 1'b0;
      end else if (clr) begin
         sreg_ff <= {W{1'b0}};
         cnt_ff  <= {CW{1'b0}};
         sdo_ff  <= 1'b0;
      end else begin
         if (load) begin
            sreg_ff <= ld_data;
            cnt_ff  <= {CW{1'b0}};
         end else if (rise) begin
            sreg_ff <= rx_word;
            cnt_ff  <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
         end
         if (load) begin
            sdo_ff <= out_en & first_bit(ld_data, lsb_first);          // [R2]
         end else if (fall) begin
            sdo_ff <= out_en & first_bit(sreg_ff, lsb_first);          // [R2]
         end else if (!out_en) begin
            sdo_ff <= 1'b0;                                            // [R2]
         end
      end
   end

endmodule // cspc_shifter

//--- cspc_top.v
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "cspc_defines.vh"

// Clocked serial port control with an APB register slave.
module cspc_top (
   // Clock and reset.
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire [31:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_ff,
   output reg         pready_ff,
   output reg         pslverr_ff,
   // Baud-rate generator half-period tick.
   input  wire        brg_tick,
   // Serial pins.
   input  wire        sck_in,
   output wire        sck_out,
   output wire        sck_oe_n,
   output wire        sdo,
   input  wire        sdi,
   // Event pulses.
   output reg         int_tx_ff,
   output reg         int_rx_ff
);

   localparam W = `CSPC_DATA_W;

   // Register state.
   reg  [7:0]   ctl_main_ff;
   reg  [2:0]   ctl_clock_ff;
   reg  [W-1:0] tx_ff;
   reg  [W-1:0] rx_ff;
   reg          ove_ff;
   reg          rx_unread_ff;
   reg          busy_ff;
   reg          tx_pend_ff;

   // Next values.
   reg  [7:0]   nxt_ctl_main;
   reg  [W-1:0] nxt_tx;
   reg  [W-1:0] load_data;
   reg          nxt_tx_pend;
   reg  [31:0]  nxt_prdata;

   // Bus decode and control fields.
   wire         acc;
   wire         wr;
   wire         rd;
   wire         pwr;
   wire         txe;
   wire         rxe;
   wire         dir;
   wire         tms;
   wire         sce;
   wire         rx_only;
   wire         run;
   wire         rise;
   wire         fall;
   wire         done;
   wire [W-1:0] rx_word;

   // Trigger and event terms.
   wire         wr_main;
   wire         wr_clock;
   wire         wr_status;
   wire         wr_tx;
   wire         rd_rx;
   wire         tx_start;
   wire         rx_start;
   wire         tx_wr_busy;
   wire         chain_tx;
   wire         chain_rx;
   wire         load;
   wire         tx_accept;

   // Address match of one register.
   function hit;
      input [31:0] a;
      input [31:0] reg_addr;
      begin
         hit = (a == reg_addr);
      end
   endfunction

   // True for any mapped address.
   function mapped;
      input [31:0] a;
      begin
         mapped = hit(a, `CSPC_ADDR_CTL_MAIN) | hit(a, `CSPC_ADDR_CTL_CLOCK) |
                  hit(a, `CSPC_ADDR_STATUS) | hit(a, `CSPC_ADDR_TX_DATA) |
                  hit(a, `CSPC_ADDR_RX_DATA);
      end
   endfunction

   // A transfer takes effect at the edge where pready is sampled high.
   assign acc       = psel & penable & pready_ff;
   assign wr        = acc & pwrite;
   assign rd        = acc & ~pwrite;
   assign wr_main   = wr & hit(paddr, `CSPC_ADDR_CTL_MAIN);
   assign wr_clock  = wr & hit(paddr, `CSPC_ADDR_CTL_CLOCK);
   assign wr_status = wr & hit(paddr, `CSPC_ADDR_STATUS);
   assign wr_tx     = wr & hit(paddr, `CSPC_ADDR_TX_DATA);
   assign rd_rx     = rd & hit(paddr, `CSPC_ADDR_RX_DATA);

   // Control fields.
   assign pwr     = ctl_main_ff[`CSPC_BIT_PWR];
   assign txe     = ctl_main_ff[`CSPC_BIT_TXE];
   assign rxe     = ctl_main_ff[`CSPC_BIT_RXE];
   assign dir     = ctl_main_ff[`CSPC_BIT_DIR];
   assign tms     = ctl_main_ff[`CSPC_BIT_TMS];
   assign sce     = ctl_main_ff[`CSPC_BIT_SCE];
   assign rx_only = ~txe & rxe;

   // Clock runs only while busy and powered, so power off stops it at once.
   assign run = busy_ff & pwr;                                         // [R5] [R24]

   // Transmit start on a data write; start enable plays no part here.
   assign tx_start = wr_tx & pwr & txe & ~busy_ff;                     // [R23] [R14]

   // Receive-only start on a read, gated by start enable, ignored while busy.
   assign rx_start = rd_rx & pwr & rx_only & ~busy_ff & sce;  // [R23] [R9] [R13] [R15]

   // A write during a continuous transfer queues the next word.
   assign tx_wr_busy = wr_tx & busy_ff & pwr & tms & txe;              // [R10]
   assign chain_tx   = done & (tx_pend_ff | tx_wr_busy);               // [R10]

   // Continuous receive-only restarts unless start enable was cleared.
   assign chain_rx = done & tms & rx_only & sce & ~chain_tx;           // [R11] [R16]
   assign load     = tx_start | rx_start | chain_tx | chain_rx;

   // Single mode drops a data write that arrives while busy.
   assign tx_accept = wr_tx & (~busy_ff | (tms & txe));                // [R8]

   // Main control write; mode bits are frozen while powered.
   always @* begin
      nxt_ctl_main = ctl_main_ff;
      if (wr_main) begin
         nxt_ctl_main[`CSPC_BIT_PWR] = pwdata[`CSPC_BIT_PWR];
         nxt_ctl_main[`CSPC_BIT_SCE] = pwdata[`CSPC_BIT_SCE];
         if (!pwr) begin
            nxt_ctl_main[`CSPC_BIT_TXE] = pwdata[`CSPC_BIT_TXE];       // [R4]
            nxt_ctl_main[`CSPC_BIT_RXE] = pwdata[`CSPC_BIT_RXE];       // [R4]
            nxt_ctl_main[`CSPC_BIT_DIR] = pwdata[`CSPC_BIT_DIR];       // [R4]
            nxt_ctl_main[`CSPC_BIT_TMS] = pwdata[`CSPC_BIT_TMS];       // [R4]
         end
         nxt_ctl_main[3:2] = 2'b00;                                    // [R19]
      end
   end

   // Transmit buffer, pending flag and the word handed to the shifter.
   always @* begin
      nxt_tx      = tx_accept ? pwdata[W-1:0] : tx_ff;
      nxt_tx_pend = tx_pend_ff;
      load_data   = tx_ff;
      if (tx_start) begin
         load_data = pwdata[W-1:0];
      end else if (chain_tx) begin
         load_data = tx_pend_ff ? tx_ff : pwdata[W-1:0];
      end
      if (chain_tx) begin
         nxt_tx_pend = tx_pend_ff & tx_wr_busy;
      end else if (tx_wr_busy) begin
         nxt_tx_pend = 1'b1;
      end
      if (!pwr) begin
         nxt_tx_pend = 1'b0;
      end
   end

   // Read data multiplexer.
   always @* begin
      nxt_prdata = 32'h0000_0000;
      if (hit(paddr, `CSPC_ADDR_CTL_MAIN)) begin
         nxt_prdata[7:0] = ctl_main_ff;
      end else if (hit(paddr, `CSPC_ADDR_CTL_CLOCK)) begin
         nxt_prdata[2:0] = ctl_clock_ff;
      end else if (hit(paddr, `CSPC_ADDR_STATUS)) begin
         nxt_prdata[`CSPC_BIT_BUSY] = busy_ff;
         nxt_prdata[`CSPC_BIT_OVE]  = ove_ff;
      end else if (hit(paddr, `CSPC_ADDR_TX_DATA)) begin
         nxt_prdata[W-1:0] = tx_ff;
      end else if (hit(paddr, `CSPC_ADDR_RX_DATA)) begin
         nxt_prdata[W-1:0] = rx_ff;
      end
   end

   // APB handshake with one wait state; unmapped addresses answer an error.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff <= psel & penable & ~pready_ff;
         if (psel && penable && !pready_ff) begin
            pslverr_ff <= ~mapped(paddr);
            prdata_ff  <= nxt_prdata;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Control registers survive power off; only bus writes change them.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_main_ff  <= `CSPC_RST_CTL_MAIN;
         ctl_clock_ff <= `CSPC_RST_CTL_CLOCK;
      end else begin
         ctl_main_ff <= nxt_ctl_main;
         if (wr_clock && !pwr) begin
            ctl_clock_ff <= pwdata[2:0];                               // [R20] [R21]
         end
      end
   end

   // Transfer state, receive data and flags; power off clears all but the transmit buffer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff      <= 1'b0;
         tx_ff        <= `CSPC_RST_DATA;
         tx_pend_ff   <= 1'b0;
         rx_ff        <= `CSPC_RST_DATA;
         rx_unread_ff <= 1'b0;
         ove_ff       <= 1'b0;
         int_tx_ff    <= 1'b0;
         int_rx_ff    <= 1'b0;
      end else if (!pwr) begin
         busy_ff      <= 1'b0;                                         // [R1]
         tx_ff        <= nxt_tx;
         tx_pend_ff   <= 1'b0;
         rx_ff        <= `CSPC_RST_DATA;                               // [R1]
         rx_unread_ff <= 1'b0;
         ove_ff       <= 1'b0;                                         // [R1]
         int_tx_ff    <= 1'b0;
         int_rx_ff    <= 1'b0;
      end else begin
         tx_ff      <= nxt_tx;
         tx_pend_ff <= nxt_tx_pend;
         // Busy rises at the trigger and falls at the last clock edge.
         if (load) begin
            busy_ff <= 1'b1;                                           // [R22]
         end else if (done) begin
            busy_ff <= 1'b0;                                           // [R22]
         end
         // Transmit interrupt marks the buffer free again, continuous mode only.
         int_tx_ff <= load & tms & txe;                                // [R7] [R10]
         // Received words land only when receive is enabled.
         int_rx_ff <= done & rxe;                                      // [R3] [R7]
         if (done && rxe) begin
            rx_ff <= rx_word;                                          // [R3]
         end
         // Unread tracking; a new word beats a read in the same cycle.
         if (done && rxe) begin
            rx_unread_ff <= 1'b1;
         end else if (rd_rx) begin
            rx_unread_ff <= 1'b0;
         end
         // Overrun: a word completes while the previous one is unread.
         if (done && rxe && rx_unread_ff && !rd_rx) begin
            ove_ff <= 1'b1;                                            // [R12]
         end else if (wr_status && !pwdata[`CSPC_BIT_OVE]) begin
            ove_ff <= 1'b0;
         end
      end
   end

   // Serial clock source.
   cspc_clock u_clock (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (run),
      .cks         (ctl_clock_ff),
      .brg_tick    (brg_tick),
      .sck_in      (sck_in),
      .sck_out_ff  (sck_out),
      .sck_oe_n_ff (sck_oe_n),
      .rise        (rise),
      .fall        (fall)
   );

   // Data shifter.
   cspc_shifter #(
      .W  (W),
      .CW (4)
   ) u_shifter (
      .pclk      (pclk),
      .presetn   (presetn),
      .clr       (~pwr),
      .load      (load),
      .ld_data   (load_data),
      .lsb_first (dir),
      .out_en    (txe & pwr),
      .rise      (rise),
      .fall      (fall),
      .sdi       (sdi),
      .sdo_ff    (sdo),
      .done      (done),
      .rx_word   (rx_word)
   );

endmodule // cspc_top

//--- cspc_top_sva.sv
`timescale 1ns/1ps
`include "cspc_defines.vh"

// Watches the pins against a snooped copy of the control registers.
module cspc_top_sva (
   // Clock and reset.
   input wire        pclk,
   input wire        presetn,
   // APB.
   input wire [31:0] paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire        pready_ff,
   input wire        pslverr_ff,
   // Serial pins and events.
   input wire        sck_out,
   input wire        sck_oe_n,
   input wire        sdo,
   input wire        int_tx_ff,
   input wire        int_rx_ff
);
   reg  [7:0] ctl_ff;
   reg  [2:0] ck_ff;
   reg        off_q_ff;
   reg        sck_q_ff;
   reg  [7:0] hc_ff;
   wire       wr_ok = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   wire       off   = ~ctl_ff[7] | ~ctl_ff[6];
   wire       mapped = paddr == `CSPC_ADDR_CTL_MAIN || paddr == `CSPC_ADDR_CTL_CLOCK ||
                       paddr == `CSPC_ADDR_STATUS || paddr == `CSPC_ADDR_TX_DATA ||
                       paddr == `CSPC_ADDR_RX_DATA;

   // Shadow control bytes; mode bits follow writes only while powered down.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff <= 8'h01;
         ck_ff <= 3'h0;
         off_q_ff <= 1'b1;
         sck_q_ff <= 1'b1;
         hc_ff <= 8'h00;
      end else begin
         if (wr_ok && paddr == `CSPC_ADDR_CTL_MAIN)
            ctl_ff <= ctl_ff[7] ? {pwdata[7], ctl_ff[6:1], pwdata[0]} : pwdata[7:0] & 8'hf3;
         if (wr_ok && paddr == `CSPC_ADDR_CTL_CLOCK && !ctl_ff[7])
            ck_ff <= pwdata[2:0];
         off_q_ff <= off;
         sck_q_ff <= sck_out;
         hc_ff <= (sck_out != sck_q_ff) ? 8'h00 : hc_ff + 8'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PREADY_WAIT: assert property (psel && penable && !pready_ff |=> pready_ff)
      else $error("pready did not follow the access phase");
   AST_PREADY_PULSE: assert property (pready_ff |=> !pready_ff)
      else $error("pready stayed high");
   AST_SLVERR_MAP: assert property (pready_ff |-> pslverr_ff == !mapped)
      else $error("slave error does not match the address map");
   AST_SDO_OFF: assert property (off && off_q_ff |-> !sdo)
      else $error("data output not low while disabled");
   AST_SCK_STOP: assert property (!ctl_ff[7] |=> sck_out)
      else $error("serial clock moved while powered down");
   AST_NO_TX_INT: assert property (int_tx_ff |-> ctl_ff[1])
      else $error("transmit event in single mode");
   AST_RX_INT_RXE: assert property (int_rx_ff |-> ctl_ff[5] && ctl_ff[7])
      else $error("receive event with reception disabled");
   AST_OE_MODE: assert property ($past(presetn) |-> sck_oe_n == ($past(ck_ff) == 3'h7))
      else $error("clock drive does not match the clock code");
   AST_HALF: assert property (ctl_ff[7] && ck_ff < 3'h6 && sck_out && !sck_q_ff |->
      hc_ff == (8'h01 << ck_ff) - 8'h01)
      else $error("serial clock low half has the wrong length");
endmodule // cspc_top_sva

bind cspc_top cspc_top_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready_ff(pready_ff),
   .pslverr_ff(pslverr_ff), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo),
   .int_tx_ff(int_tx_ff), .int_rx_ff(int_rx_ff));

//--- cspc_partner.sv
`timescale 1ns/1ps

// Serial peripheral stand-in: shifts its byte out MSB first, captures the port's output.
module cspc_partner (
   // Clocks and control.
   input  wire       pclk,
   input  wire       clr,
   input  wire       sck,
   // Serial data.
   input  wire       sdo,
   input  wire [7:0] pbyte,
   output wire       sdi,
   output reg  [7:0] prx
);
   reg [3:0] fc_ff = 4'h8;
   reg [3:0] rc_ff = 4'h8;
   reg       bit_ff = 1'b0;
   reg       noise_ff = 1'b0;
   reg       idle_ff = 1'b1;
   wire      idle = (fc_ff == 4'h8) && (rc_ff == 4'h8);

   // Outside a frame the line is released, but only one clock after the last edge.
   assign sdi = (idle && idle_ff) ? noise_ff : bit_ff;

   // A new bit goes out on every falling clock edge.
   always @(negedge sck or posedge clr) begin
      if (clr) begin
         fc_ff <= 4'h8;
      end else begin
         bit_ff <= pbyte[(fc_ff == 4'h8) ? 3'h7 : 3'h7 - fc_ff[2:0]];
         fc_ff <= (fc_ff == 4'h8) ? 4'h1 : fc_ff + 4'h1;
      end
   end

   // The port's output is captured on every rising clock edge.
   always @(posedge sck or posedge clr) begin
      if (clr) begin
         rc_ff <= 4'h8;
      end else begin
         prx <= {prx[6:0], sdo};
         rc_ff <= (rc_ff == 4'h8) ? 4'h1 : rc_ff + 4'h1;
      end
   end

   // Noise source for the released line.
   always @(posedge pclk) begin
      noise_ff <= ~noise_ff;
      idle_ff  <= idle;
   end
endmodule // cspc_partner

//--- cspc_top_tb.sv
`timescale 1ns/1ps
`include "cspc_defines.vh"

// Self-checking bench for the serial port control block.
module cspc_top_tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg  [31:0] paddr = 32'h0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [31:0] pwdata = 32'h0;
   reg         brg_tick = 1'b0;
   reg         clr = 1'b0;
   reg  [7:0]  pbyte = 8'h00;
   reg         ext_sck = 1'b1;
   wire [31:0] prdata_ff;
   wire        pready_ff, pslverr_ff, sck_out, sck_oe_n, sdo, sdi, int_tx_ff, int_rx_ff;
   wire [7:0]  prx;
   wire        sck_w = sck_oe_n ? ext_sck : sck_out;
   integer     n_fail = 0, comparisons = 0, seed = 32'h19c6, k, i;
   reg  [31:0] q;
   reg         e;
   reg  [7:0]  tx, tx2;

   cspc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .brg_tick(brg_tick), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe_n(sck_oe_n), .sdo(sdo), .sdi(sdi), .int_tx_ff(int_tx_ff), .int_rx_ff(int_rx_ff));
   cspc_partner u_partner (.pclk(pclk), .clr(clr), .sck(sck_w), .sdo(sdo), .pbyte(pbyte),
      .sdi(sdi), .prx(prx));

   // Clock and a baud tick every other cycle.
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) brg_tick <= ~brg_tick;

   task report_and_stop;
      begin
         if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask

   task chk(input [31:0] g, input [31:0] x);
      begin
         comparisons = comparisons + 1;
         if (g !== x) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
         end
      end
   endtask

   // One APB transfer; the request stands until pready is sampled high.
   task apb(input wr, input [31:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         i = 0;
         do begin
            @(posedge pclk);
            i = i + 1;
         end while (pready_ff !== 1'b1 && i < 20);
         q = prdata_ff;
         e = pslverr_ff;
         psel <= 1'b0;
         penable <= 1'b0;
         if (i >= 20) begin
            n_fail = n_fail + 1;
            report_and_stop;
         end
      end
   endtask

   // Waits a bounded time for an event pulse.
   task wait_int(input t);
      begin
         i = 0;
         do begin
            @(posedge pclk);
            i = i + 1;
         end while ((t ? int_tx_ff : int_rx_ff) !== 1'b1 && i < 4000);
         if (i >= 4000) begin
            n_fail = n_fail + 1;
            report_and_stop;
         end
      end
   endtask

   // Powers down, sets the clock code, then writes the main control byte.
   task cfg(input [2:0] ck, input [7:0] ctl);
      begin
         clr <= 1'b1;
         apb(1'b1, `CSPC_ADDR_CTL_MAIN, 32'h0);
         clr <= 1'b0;
         apb(1'b1, `CSPC_ADDR_CTL_CLOCK, {29'h0, ck});
         apb(1'b1, `CSPC_ADDR_CTL_MAIN, {24'h0, ctl & 8'hf3});
      end
   endtask

   // Byte as seen after crossing the wire in the given order.
   function [7:0] rev(input [7:0] v, input d);
      integer j;
      begin
         for (j = 0; j < 8; j = j + 1) rev[j] = d ? v[7 - j] : v[j];
      end
   endfunction

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, an unmapped address and slave clock mode.
      apb(1'b0, `CSPC_ADDR_CTL_MAIN, 32'h0);
      chk(q, 32'h0000_0001);
      apb(1'b0, `CSPC_ADDR_CTL_CLOCK, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `CSPC_ADDR_CTL_MAIN + 32'h0000_0100, 32'h0);
      chk({31'h0, e}, 32'h1);
      cfg(3'h7, 8'he1);
      chk({31'h0, sck_oe_n}, 32'h1);
      tx = $random(seed);
      pbyte <= $random(seed);
      apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx});
      repeat (16) begin
         repeat (2) @(posedge pclk);
         ext_sck <= ~ext_sck;
      end
      wait_int(1'b0);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      chk(q, {24'h0, pbyte});
      chk({24'h0, prx}, {24'h0, tx});
      // Single transfers at every master clock code, both bit orders.
      for (k = 0; k < 7; k = k + 1) begin
         tx = $random(seed);
         tx2 = $random(seed);
         pbyte <= $random(seed);
         cfg(k[2:0], 8'he1 | {3'h0, k[0], 4'h0});
         apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx});
         apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx2});
         wait_int(1'b0);
         apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
         chk(q, {24'h0, rev(pbyte, k[0])});
         chk({24'h0, prx}, {24'h0, rev(tx, k[0])});
         apb(1'b0, `CSPC_ADDR_TX_DATA, 32'h0);
         chk(q, {24'h0, tx});
         apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
         chk(q, 32'h0);
      end
      // Receive-only single transfers start on a read.
      cfg(3'h0, 8'ha1);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      wait_int(1'b0);
      apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, `CSPC_ADDR_CTL_MAIN, 32'h0000_00a0);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      chk(q, {24'h0, pbyte});
      apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
      chk(q, 32'h0);
      // Continuous reception left unread, then stopped.
      cfg(3'h1, 8'ha3);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      wait_int(1'b0);
      wait_int(1'b0);
      apb(1'b1, `CSPC_ADDR_CTL_MAIN, 32'h0000_00a2);
      apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
      chk(q & 32'h1, 32'h1);
      wait_int(1'b0);
      apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
      chk(q & 32'h80, 32'h0);
      // Continuous transmit chains a second word written after the transmit event.
      cfg(3'h2, 8'he2);
      apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx});
      wait_int(1'b1);
      apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx2});
      wait_int(1'b0);
      wait_int(1'b0);
      chk({24'h0, prx}, {24'h0, tx2});
      // Transmit with reception off leaves the receive data untouched.
      cfg(3'h0, 8'hc1);
      apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx});
      k = 0;
      do begin
         apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
         k = k + 1;
      end while (q[7] !== 1'b0 && k < 50);
      apb(1'b0, `CSPC_ADDR_RX_DATA, 32'h0);
      chk(q, 32'h0);
      // Power-down in mid-transfer.
      cfg(3'h5, 8'he1);
      apb(1'b1, `CSPC_ADDR_TX_DATA, {24'h0, tx});
      repeat (100) @(posedge pclk);
      apb(1'b1, `CSPC_ADDR_CTL_MAIN, 32'h0);
      apb(1'b0, `CSPC_ADDR_STATUS, 32'h0);
      chk(q, 32'h0);
      chk({30'h0, sck_out, sdo}, 32'h2);
      report_and_stop;
   end
endmodule // cspc_top_tb
